// file: core/pscnt_top.sv
`timescale 1ns/1ns
`default_nettype none
module pscnt_top #(
    parameter int NPORTS = 10,  // Ethernet ports counted
    parameter int PW     = 4    // Port number width
) (
    // Clock and reset
    input  wire logic              I_MCLK,
    input  wire logic              I_NRST,
    // Receive frame report from the MAC
    input  wire logic              I_RX_VALID,
    output logic                   O_RX_READY,
    input  wire logic [PW-1:0]     I_RX_PORT,
    input  wire logic [13:0]       I_RX_LEN,
    input  wire logic              I_RX_FCS_ERR,
    input  wire logic              I_RX_ALIGN_ERR,
    input  wire logic              I_RX_COLL,
    input  wire logic              I_RX_TAGGED,
    input  wire logic              I_RX_MCAST,
    input  wire logic              I_RX_BCAST,
    input  wire logic              I_RX_PAUSE,
    input  wire logic              I_RX_DROP,
    input  wire logic              I_RX_LIMIT_EN,
    input  wire logic [13:0]       I_RX_LIMIT,
    // Transmit frame report from the MAC
    input  wire logic              I_TX_VALID,
    output logic                   O_TX_READY,
    input  wire logic [PW-1:0]     I_TX_PORT,
    input  wire logic [13:0]       I_TX_LEN,
    input  wire logic              I_TX_UNICAST,
    input  wire logic              I_TX_PAUSE,
    input  wire logic              I_TX_UNDERRUN,
    input  wire logic              I_TX_LATE_COLL,
    input  wire logic [4:0]        I_TX_COLL_CNT,
    // Delay-exceeded discard from the buffer manager
    input  wire logic              I_BM_VALID,
    output logic                   O_BM_READY,
    input  wire logic [PW-1:0]     I_BM_PORT,
    // Filtered frame from the queue manager
    input  wire logic              I_QM_VALID,
    output logic                   O_QM_READY,
    input  wire logic [PW-1:0]     I_QM_PORT,
    // Processor counter read
    input  wire logic              I_CPU_RD,
    input  wire logic [PW-1:0]     I_CPU_PORT,
    input  wire logic [3:0]        I_CPU_WORD,
    output logic                   O_CPU_RVALID,
    output logic      [31:0]       O_CPU_RDATA,
    // Wrap notification to the command block
    output logic                   O_WRAP_VALID,
    input  wire logic              I_WRAP_READY,
    output logic      [63:0]       O_WRAP_WORD
);

    //==========================================================
    // Declarations
    //==========================================================
    localparam int AW = PW + pscnt_pkg::WIDX_W;  // Memory address width

    typedef enum logic [2:0] {
        PSCNT_INIT, PSCNT_IDLE, PSCNT_READ, PSCNT_UPDATE, PSCNT_NOTIFY
    } pscnt_state_t;

    pscnt_state_t      state_ff, nxt_state;     // Sequencer state
    logic [PW-1:0]     port_ff, nxt_port;       // Port being updated
    logic [3:0]        word_ff, nxt_word;       // Word being updated
    logic [29:0][31:0] incr_ff, nxt_incr;       // Latched increments
    logic [29:0]       wrap_ff, nxt_wrap;       // Collected wrap flags
    logic [AW-1:0]     init_ff, nxt_init;       // Clearing sweep address
    logic              rvalid_ff, nxt_rvalid;   // Processor read answer

    logic [29:0][31:0] rx_incr, tx_incr;        // Classified increments
    logic [29:0][31:0] bm_incr, qm_incr;
    logic [13:0]       max_len;                 // Maximum frame size
    logic              in_range, rx_short;      // Size classes
    logic              rx_long, rx_under;
    logic              idle;                    // Sequencer free

    logic              mem_we;                  // Memory write strobe
    logic [AW-1:0]     mem_waddr, mem_raddr;
    logic [31:0]       mem_wdata, mem_rdata;
    logic [31:0]       upd_new;                 // Updated word
    logic [29:0]       upd_wrap;                // Rollovers in this word

    //==========================================================
    // Receive classifier
    //==========================================================
    // maximum size by tag or buffer limit
    assign max_len  = I_RX_LIMIT_EN ? I_RX_LIMIT
                    : (I_RX_TAGGED ? pscnt_pkg::LEN_MAX_TAG : pscnt_pkg::LEN_MAX_UNTAG);
    assign in_range = (I_RX_LEN >= pscnt_pkg::LEN_MIN) && (I_RX_LEN <= max_len);
    assign rx_long  = (I_RX_LEN > max_len);
    assign rx_under = (I_RX_LEN < pscnt_pkg::LEN_MIN);
    assign rx_short = (I_RX_LEN < pscnt_pkg::LEN_SHORT);

    // Map one received frame onto counter increments
    always_comb begin
        logic good;
        logic nc;
        good    = 1'b0;
        nc      = 1'b0;
        rx_incr = '0;
        nc      = !I_RX_COLL;
        good    = nc && in_range && !I_RX_FCS_ERR && !I_RX_ALIGN_ERR;
        rx_incr[5]  = nc ? 32'(I_RX_LEN) : 32'h0;
        rx_incr[6]  = 32'(nc);
        rx_incr[7]  = 32'(I_RX_LEN);
        rx_incr[8]  = 32'h1;
        rx_incr[9]  = 32'(I_RX_PAUSE);
        rx_incr[10] = 32'(good && I_RX_MCAST && !I_RX_BCAST);
        rx_incr[11] = 32'(good && I_RX_BCAST);
        // size histogram, good and bad frames
        rx_incr[12] = 32'(I_RX_LEN == pscnt_pkg::LEN_MIN);
        rx_incr[13] = 32'(nc && rx_long && I_RX_FCS_ERR);
        rx_incr[14] = 32'(I_RX_LEN > pscnt_pkg::LEN_MIN && I_RX_LEN <= pscnt_pkg::LEN_127);
        rx_incr[15] = 32'(nc && rx_long);
        rx_incr[16] = 32'(I_RX_LEN > pscnt_pkg::LEN_127 && I_RX_LEN <= pscnt_pkg::LEN_255);
        rx_incr[17] = 32'(I_RX_LEN > pscnt_pkg::LEN_255 && I_RX_LEN <= pscnt_pkg::LEN_511);
        rx_incr[18] = 32'(I_RX_LEN > pscnt_pkg::LEN_511 && I_RX_LEN <= pscnt_pkg::LEN_1023);
        rx_incr[19] = 32'(I_RX_LEN > pscnt_pkg::LEN_1023 && I_RX_LEN <= max_len);
        rx_incr[20] = 32'(nc && rx_under && I_RX_FCS_ERR);
        rx_incr[21] = 32'(nc && in_range && I_RX_ALIGN_ERR);
        rx_incr[22] = 32'(nc && rx_under && !I_RX_FCS_ERR && !I_RX_ALIGN_ERR);
        rx_incr[23] = 32'(nc && in_range && I_RX_FCS_ERR && !I_RX_ALIGN_ERR);
        rx_incr[24] = 32'(nc && rx_short);
        rx_incr[26] = 32'(I_RX_DROP);
    end

    //==========================================================
    // Transmit classifier
    //==========================================================
    always_comb begin
        tx_incr    = '0;
        tx_incr[0] = 32'(I_TX_LEN);
        tx_incr[1] = 32'(I_TX_UNICAST);
        tx_incr[2] = 32'(I_TX_UNDERRUN || I_TX_LATE_COLL
                         || (I_TX_COLL_CNT >= pscnt_pkg::COLL_LIMIT));
        tx_incr[3] = 32'(I_TX_PAUSE);
        tx_incr[4] = 32'(!I_TX_UNICAST);
        tx_incr[25] = 32'(I_TX_COLL_CNT);
        tx_incr[29] = 32'(I_TX_LATE_COLL);
    end

    // manager events count on their own
    always_comb begin
        bm_incr     = '0;
        qm_incr     = '0;
        bm_incr[28] = 32'h1;
        qm_incr[27] = 32'h1;
    end

    //==========================================================
    // Source arbitration: receive, transmit, buffer, queue
    //==========================================================
    assign idle       = (state_ff == PSCNT_IDLE);
    assign O_RX_READY = idle;
    assign O_TX_READY = idle && !I_RX_VALID;
    assign O_BM_READY = idle && !I_RX_VALID && !I_TX_VALID;
    assign O_QM_READY = idle && !I_RX_VALID && !I_TX_VALID && !I_BM_VALID;

    //==========================================================
    // Sequencer
    //==========================================================
    // Next state: clear sweep, then read-modify-write all words
    always_comb begin
        nxt_state = state_ff;
        nxt_port  = port_ff;
        nxt_word  = word_ff;
        nxt_incr  = incr_ff;
        nxt_wrap  = wrap_ff;
        nxt_init  = init_ff;
        case (state_ff)
            // Zero every counter after reset
            PSCNT_INIT: begin
                nxt_init = init_ff + {{(AW-1){1'b0}}, 1'b1};
                if (&init_ff) begin
                    nxt_state = PSCNT_IDLE;
                end
            end
            // Take one event, highest priority first
            PSCNT_IDLE: begin
                nxt_word = 4'h0;
                nxt_wrap = '0;
                if (I_RX_VALID) begin
                    nxt_port  = I_RX_PORT;
                    nxt_incr  = rx_incr;
                    nxt_state = PSCNT_READ;
                end else if (I_TX_VALID) begin
                    nxt_port  = I_TX_PORT;
                    nxt_incr  = tx_incr;
                    nxt_state = PSCNT_READ;
                end else if (I_BM_VALID) begin
                    nxt_port  = I_BM_PORT;
                    nxt_incr  = bm_incr;
                    nxt_state = PSCNT_READ;
                end else if (I_QM_VALID) begin
                    nxt_port  = I_QM_PORT;
                    nxt_incr  = qm_incr;
                    nxt_state = PSCNT_READ;
                end
            end
            // Address presented, data registered next cycle
            PSCNT_READ: begin
                nxt_state = PSCNT_UPDATE;
            end
            // Write updated word, gather rollovers
            PSCNT_UPDATE: begin
                nxt_wrap = wrap_ff | upd_wrap;
                nxt_word = word_ff + 4'h1;
                if (word_ff == pscnt_pkg::W_LAST) begin
                    // notify only when something rolled over
                    nxt_state = |(wrap_ff | upd_wrap) ? PSCNT_NOTIFY : PSCNT_IDLE;
                end else begin
                    nxt_state = PSCNT_READ;
                end
            end
            // each flag sent once, then dropped
            PSCNT_NOTIFY: begin
                if (I_WRAP_READY) begin
                    nxt_wrap  = '0;
                    nxt_state = PSCNT_IDLE;
                end
            end
            default: begin
                nxt_state = PSCNT_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_ff <= PSCNT_INIT;
            port_ff  <= '0;
            word_ff  <= 4'h0;
            incr_ff  <= '0;
            wrap_ff  <= '0;
            init_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            port_ff  <= nxt_port;
            word_ff  <= nxt_word;
            incr_ff  <= nxt_incr;
            wrap_ff  <= nxt_wrap;
            init_ff  <= nxt_init;
        end
    end

    //==========================================================
    // Counter memory and word update
    //==========================================================
    // one address block per port
    assign mem_raddr = {port_ff, word_ff};
    assign mem_we    = (state_ff == PSCNT_UPDATE) || (state_ff == PSCNT_INIT);
    assign mem_waddr = (state_ff == PSCNT_INIT) ? init_ff : {port_ff, word_ff};
    assign mem_wdata = (state_ff == PSCNT_INIT) ? 32'h0 : upd_new;

    pscnt_mem #(
        .AW (AW),
        .DW (pscnt_pkg::WORD_W)
    ) u_mem (
        .i_clk     (I_MCLK),
        .i_we      (mem_we),
        .i_waddr   (mem_waddr),
        .i_wdata   (mem_wdata),
        .i_raddr_a (mem_raddr),
        .o_rdata_a (mem_rdata),
        .i_raddr_b ({I_CPU_PORT, I_CPU_WORD}),
        .o_rdata_b (O_CPU_RDATA)
    );

    pscnt_upd u_upd (
        .i_word (word_ff),
        .i_old  (mem_rdata),
        .i_incr (incr_ff),
        .o_new  (upd_new),
        .o_wrap (upd_wrap)
    );

    //==========================================================
    // Processor read answer
    //==========================================================
    // read leaves the counter untouched
    assign nxt_rvalid = I_CPU_RD;

    // Answer flag one cycle after the request
    always_ff @(posedge I_MCLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign O_CPU_RVALID = rvalid_ff;

    //==========================================================
    // Wrap notification word
    //==========================================================
    assign O_WRAP_VALID = (state_ff == PSCNT_NOTIFY);
    assign O_WRAP_WORD  = {{(pscnt_pkg::WRAP_W - pscnt_pkg::WRAP_PORT_LSB - PW){1'b0}},
                           port_ff, wrap_ff};

endmodule
`default_nettype wire

// file: core/pscnt_pkg.sv
//==============================================================
// Port statistics counter bank: shared constants
//==============================================================
package pscnt_pkg;

    //==========================================================
    // Geometry
    //==========================================================
    localparam int NUM_FLAGS   = 30;  // Wrap flags, one per counter
    localparam int WORD_W      = 32;  // Counter memory word width
    localparam int WIDX_W      = 4;   // Word index width, sixteen words per port
    localparam int LEN_W       = 14;  // Frame length field width
    localparam int WRAP_W      = 64;  // Wrap notification word width
    localparam int WRAP_PORT_LSB = 30; // Port number sits above the flags

    //==========================================================
    // Word indices of the per-port counter memory
    //==========================================================
    localparam logic [3:0] W_TX_BYTE      = 4'h0;
    localparam logic [3:0] W_TX_UC_FAIL   = 4'h1;
    localparam logic [3:0] W_TX_PAUSE_NUC = 4'h2;
    localparam logic [3:0] W_RX_BYTE      = 4'h3;
    localparam logic [3:0] W_RX_FRAME     = 4'h4;
    localparam logic [3:0] W_RX_TOT_BYTE  = 4'h5;
    localparam logic [3:0] W_RX_TOT_PAUSE = 4'h6;
    localparam logic [3:0] W_RX_GROUP     = 4'h7;
    localparam logic [3:0] W_SZ64_JAB     = 4'h8;
    localparam logic [3:0] W_SZ65_OVR     = 4'h9;
    localparam logic [3:0] W_SZ128_256    = 4'ha;
    localparam logic [3:0] W_SZ512_1024   = 4'hb;
    localparam logic [3:0] W_FRAG_AL_UND  = 4'hc;
    localparam logic [3:0] W_CRC_SHORT    = 4'hd;
    localparam logic [3:0] W_COLL_DROP    = 4'he;
    localparam logic [3:0] W_FILT_DLY_LC  = 4'hf;
    localparam logic [3:0] W_LAST         = 4'hf;

    //==========================================================
    // Field table, indexed by wrap flag number
    //==========================================================
    // Word holding each counter
    localparam logic [3:0] FLD_WORD [0:NUM_FLAGS-1] = '{
        W_TX_BYTE, W_TX_UC_FAIL, W_TX_UC_FAIL, W_TX_PAUSE_NUC, W_TX_PAUSE_NUC,
        W_RX_BYTE, W_RX_FRAME, W_RX_TOT_BYTE, W_RX_TOT_PAUSE, W_RX_TOT_PAUSE,
        W_RX_GROUP, W_RX_GROUP, W_SZ64_JAB, W_SZ64_JAB, W_SZ65_OVR,
        W_SZ65_OVR, W_SZ128_256, W_SZ128_256, W_SZ512_1024, W_SZ512_1024,
        W_FRAG_AL_UND, W_FRAG_AL_UND, W_FRAG_AL_UND, W_CRC_SHORT, W_CRC_SHORT,
        W_COLL_DROP, W_COLL_DROP, W_FILT_DLY_LC, W_FILT_DLY_LC, W_FILT_DLY_LC};
    // Lowest bit of each counter within its word
    localparam int FLD_LSB [0:NUM_FLAGS-1] = '{
        0, 0, 24, 0, 16, 0, 0, 0, 0, 24, 0, 16, 0, 24, 0,
        24, 0, 16, 0, 16, 0, 16, 24, 0, 16, 0, 16, 0, 16, 24};
    // Width of each counter
    localparam int FLD_W [0:NUM_FLAGS-1] = '{
        32, 24, 8, 16, 16, 32, 32, 32, 24, 8, 16, 16, 24, 8, 24,
        8, 16, 16, 16, 16, 16, 8, 8, 16, 16, 16, 16, 16, 8, 8};

    //==========================================================
    // Frame size thresholds in bytes, and the transmit collision limit
    //==========================================================
    localparam logic [13:0] LEN_SHORT     = 14'h000a;  // 10
    localparam logic [13:0] LEN_MIN       = 14'h0040;  // 64
    localparam logic [13:0] LEN_127       = 14'h007f;
    localparam logic [13:0] LEN_255       = 14'h00ff;
    localparam logic [13:0] LEN_511       = 14'h01ff;
    localparam logic [13:0] LEN_1023      = 14'h03ff;
    localparam logic [13:0] LEN_MAX_TAG   = 14'h05f2;  // 1522
    localparam logic [13:0] LEN_MAX_UNTAG = 14'h05ee;  // 1518
    localparam logic [4:0]  COLL_LIMIT    = 5'h10;     // 16 collisions

endpackage

// file: core/pscnt_mem.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Counter memory: one write port, two registered read ports
//==============================================================
module pscnt_mem #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    // Clock
    input  wire logic          i_clk,
    // Write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    // Update read port
    input  wire logic [AW-1:0] i_raddr_a,
    output logic      [DW-1:0] o_rdata_a,
    // Processor read port
    input  wire logic [AW-1:0] i_raddr_b,
    output logic      [DW-1:0] o_rdata_b
);

    logic [DW-1:0] mem [0:(2**AW)-1];  // Counter storage

    // Write, and register both read words (old data on collision)
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata_a <= mem[i_raddr_a];
        o_rdata_b <= mem[i_raddr_b];
    end

endmodule
`default_nettype wire

// file: core/pscnt_upd.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Word update: adds increments to every counter of one word
//==============================================================
module pscnt_upd (
    // Word being updated
    input  wire logic [3:0]        i_word,
    input  wire logic [31:0]       i_old,
    // Increment per counter
    input  wire logic [29:0][31:0] i_incr,
    // Result
    output logic      [31:0]       o_new,
    output logic      [29:0]       o_wrap
);

    logic [29:0][31:0] contrib;  // Each counter's bits in its place

    //==========================================================
    // One adder per counter
    //==========================================================
    for (genvar f = 0; f < pscnt_pkg::NUM_FLAGS; f++) begin : g_fld
        localparam logic [32:0] M = (33'h1 << pscnt_pkg::FLD_W[f]) - 33'h1;
        logic        hit;   // Counter lives in this word
        logic [32:0] fld;   // Current value
        logic [32:0] sum;   // Value plus increment
        assign hit = (i_word == pscnt_pkg::FLD_WORD[f]);
        assign fld = ({1'b0, i_old} >> pscnt_pkg::FLD_LSB[f]) & M;
        assign sum = fld + {1'b0, i_incr[f]};
        assign contrib[f] = hit ? 32'((sum & M) << pscnt_pkg::FLD_LSB[f]) : 32'h0;
        assign o_wrap[f] = hit && (sum > M);
    end

    // Merge fields; fields of a word cover all 32 bits
    always_comb begin
        o_new = 32'h0;
        for (int k = 0; k < pscnt_pkg::NUM_FLAGS; k++) begin
            o_new = o_new | contrib[k];
        end
    end

endmodule
`default_nettype wire

// file: tb/pscnt_checker.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Port checks of the counter bank
//==============================================================
module pscnt_checker (
    // Watched ports
    input wire logic        I_MCLK, I_NRST, I_RX_VALID, O_RX_READY, O_TX_READY,
    input wire logic        I_CPU_RD, O_CPU_RVALID, O_WRAP_VALID, I_WRAP_READY,
    input wire logic [63:0] O_WRAP_WORD
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    rd_answer_a: assert property (I_CPU_RD |=> O_CPU_RVALID)
        else $error("read strobe not answered");
    rd_cause_a: assert property (O_CPU_RVALID |-> $past(I_CPU_RD))
        else $error("read answer without strobe");
    wrap_hold_a: assert property (O_WRAP_VALID && !I_WRAP_READY |=> O_WRAP_VALID && $stable(O_WRAP_WORD))
        else $error("wrap word not held");
    wrap_once_a: assert property (O_WRAP_VALID && I_WRAP_READY |=> !O_WRAP_VALID)
        else $error("wrap word repeated");
    wrap_upper_a: assert property (O_WRAP_VALID |-> O_WRAP_WORD[63:34] == 30'h0)
        else $error("wrap word upper bits set");
    wrap_flag_a: assert property (O_WRAP_VALID |-> O_WRAP_WORD[29:0] != 30'h0)
        else $error("wrap word without flag");
    upd_busy_a: assert property (I_RX_VALID && O_RX_READY |=> !O_RX_READY [*8])
        else $error("update too short");
    rx_first_a: assert property (I_RX_VALID |-> !O_TX_READY)
        else $error("transmit taken over receive");
    wrap_stall_a: assert property (O_WRAP_VALID |-> !O_RX_READY)
        else $error("event taken while notifying");
endmodule
bind pscnt_top pscnt_checker i_chk (.I_MCLK, .I_NRST, .I_RX_VALID, .O_RX_READY, .O_TX_READY,
    .I_CPU_RD, .O_CPU_RVALID, .O_WRAP_VALID, .I_WRAP_READY, .O_WRAP_WORD);
`default_nettype wire

// file: tb/pscnt_cmd_model.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// Command block model: takes wrap words after a stall
//==============================================================
module pscnt_cmd_model (
    input  wire logic        i_clk, i_rst_n, i_valid,
    input  wire logic [63:0] i_word,
    input  wire logic [3:0]  i_delay,
    output logic             o_ready,
    output logic [7:0]       o_count,
    output logic [63:0]      o_last
);
    logic [3:0] wait_ff;  // Cycles the pending word has waited
    // Ready after i_delay+1 stalled cycles, one pulse per word
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'b0;
            wait_ff <= 4'h0;
            o_count <= 8'h00;
            o_last <= 64'h0;
        end else begin
            o_ready <= i_valid && !o_ready && wait_ff >= i_delay;
            wait_ff <= (i_valid && !o_ready) ? wait_ff + 4'h1 : 4'h0;
            if (i_valid && o_ready) begin
                o_count <= o_count + 8'h01;
                o_last <= i_word;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    //==========================================================
    // Stimulus and observed signals
    //==========================================================
    logic        mclk, nrst, cpu_rd, rvalid, wvalid, wready, lim_en;
    logic [3:0]  ev_valid, rx_port, tx_port, mg_port, cpu_port, cpu_word, tx_q, wdelay;
    logic [13:0] rx_len, tx_len, lim;  // Buffer limit, used while lim_en
    logic [7:0]  rx_q, wcount;  // Receive: fcs align coll tag mcast bcast pause drop
    logic [4:0]  tx_coll;
    logic [31:0] rdata;
    logic [63:0] wword, wlast;
    wire  [3:0]  ev_ready;
    int          errors, checked;
    pscnt_top i_dut (.I_MCLK(mclk), .I_NRST(nrst),
        .I_RX_VALID(ev_valid[0]), .O_RX_READY(ev_ready[0]), .I_RX_PORT(rx_port),
        .I_RX_LEN(rx_len), .I_RX_FCS_ERR(rx_q[7]), .I_RX_ALIGN_ERR(rx_q[6]),
        .I_RX_COLL(rx_q[5]), .I_RX_TAGGED(rx_q[4]), .I_RX_MCAST(rx_q[3]),
        .I_RX_BCAST(rx_q[2]), .I_RX_PAUSE(rx_q[1]), .I_RX_DROP(rx_q[0]),
        .I_RX_LIMIT_EN(lim_en), .I_RX_LIMIT(lim),
        .I_TX_VALID(ev_valid[1]), .O_TX_READY(ev_ready[1]), .I_TX_PORT(tx_port),
        .I_TX_LEN(tx_len), .I_TX_UNICAST(tx_q[3]), .I_TX_PAUSE(tx_q[2]),
        .I_TX_UNDERRUN(tx_q[1]), .I_TX_LATE_COLL(tx_q[0]), .I_TX_COLL_CNT(tx_coll),
        .I_BM_VALID(ev_valid[2]), .O_BM_READY(ev_ready[2]), .I_BM_PORT(mg_port),
        .I_QM_VALID(ev_valid[3]), .O_QM_READY(ev_ready[3]), .I_QM_PORT(mg_port),
        .I_CPU_RD(cpu_rd), .I_CPU_PORT(cpu_port), .I_CPU_WORD(cpu_word),
        .O_CPU_RVALID(rvalid), .O_CPU_RDATA(rdata),
        .O_WRAP_VALID(wvalid), .I_WRAP_READY(wready), .O_WRAP_WORD(wword));
    pscnt_cmd_model i_cmd (.i_clk(mclk), .i_rst_n(nrst), .i_valid(wvalid), .i_word(wword),
        .i_delay(wdelay), .o_ready(wready), .o_count(wcount), .o_last(wlast));
    //==========================================================
    // Tasks
    //==========================================================
    task automatic cmp(input string what, input logic [63:0] exp, got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Wait until source k is ready, bounded
    task automatic wait_rdy(input int k);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ev_ready[k] !== 1'b1 && n < 400);
        cmp("source ready", 64'h1, ev_ready[k]);
    endtask
    // Hold valid until taken, then drop it
    task automatic hs(input int k);
        wait_rdy(k);
        @(posedge mclk) ev_valid[k] <= 1'b0;
    endtask
    task automatic rx(input logic [3:0] p, input logic [13:0] len, input logic [7:0] q);
        @(posedge mclk) begin
            {rx_port, rx_len, rx_q} <= {p, len, q};
            ev_valid[0] <= 1'b1;
        end
        hs(0);
    endtask
    task automatic tx(input logic [3:0] p, input logic [13:0] len, q, input logic [4:0] c);
        @(posedge mclk) begin
            {tx_port, tx_len, tx_q, tx_coll} <= {p, len, q[3:0], c};
            ev_valid[1] <= 1'b1;
        end
        hs(1);
    endtask
    task automatic mgr(input int k, input logic [3:0] p);
        @(posedge mclk) begin
            mg_port <= p;
            ev_valid[k] <= 1'b1;
        end
        hs(k);
    endtask
    // Read one word once the update has finished
    task automatic rd(input logic [3:0] p, w, input logic [31:0] exp);
        wait_rdy(0);
        @(posedge mclk) {cpu_rd, cpu_port, cpu_word} <= {1'b1, p, w};
        @(posedge mclk) cpu_rd <= 1'b0;
        @(negedge mclk);
        cmp("read valid", 64'h1, rvalid);
        cmp("read data", exp, rdata);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    //==========================================================
    // Clock, watchdog and tests
    //==========================================================
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {nrst, cpu_rd, ev_valid, rx_port, tx_port, mg_port, cpu_port, cpu_word} = '0;
        {tx_q, rx_len, tx_len, rx_q, tx_coll, errors, checked, lim_en, lim} = '0;
        wdelay = 4'h5;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        rd(4'h0, 4'h0, 32'h0);
        tx(4'h1, 14'd100, 4'h8, 5'h00);
        rd(4'h1, 4'h0, 32'd100);
        tx(4'h1, 14'd64, 4'h0, 5'h10);
        rd(4'h1, 4'h2, 32'h00010000);
        rd(4'h1, 4'he, 32'h00000010);
        tx(4'h1, 14'd64, 4'h1, 5'h00);
        rd(4'h1, 4'hf, 32'h01000000);
        tx(4'h1, 14'd64, 4'h2, 5'h00);
        rd(4'h1, 4'h1, 32'h03000001);
        $display("test transmit done");
        rx(4'h2, 14'd64, 8'h00);
        rd(4'h2, 4'h3, 32'd64);
        rd(4'h2, 4'h4, 32'h1);
        rx(4'h2, 14'd5, 8'h80);
        rd(4'h2, 4'hd, 32'h00010000);
        rd(4'h2, 4'hc, 32'h00000001);
        rx(4'h2, 14'd1600, 8'h90);
        rd(4'h2, 4'h8, 32'h01000001);
        rd(4'h2, 4'h9, 32'h01000000);
        rx(4'h2, 14'd300, 8'h04);
        rd(4'h2, 4'h7, 32'h00010000);
        rd(4'h2, 4'ha, 32'h00010000);
        @(posedge mclk) {lim_en, lim} <= {1'b1, 14'd200};
        rx(4'h5, 14'd300, 8'h80);
        rd(4'h5, 4'h8, 32'h01000000);
        rx(4'h5, 14'd100, 8'h0b);
        rd(4'h5, 4'h7, 32'h00000001);
        rd(4'h5, 4'h6, 32'h01000002);
        rd(4'h5, 4'he, 32'h00010000);
        tx(4'h5, 14'd64, 4'hc, 5'h00);
        rd(4'h5, 4'h2, 32'h00000001);
        $display("test receive done");
        mgr(2, 4'h3);
        mgr(3, 4'h3);
        rd(4'h3, 4'hf, 32'h00010001);
        $display("test managers done");
        repeat (256) tx(4'h4, 14'd64, 4'h2, 5'h00);
        for (int n = 0; n < 300 && wcount !== 8'h01; n++) @(negedge mclk);
        cmp("wrap count", 64'h1, wcount);
        cmp("wrap word", 64'h0000_0001_0000_0004, wlast);
        rd(4'h4, 4'h1, 32'h0);
        rd(4'h4, 4'h0, 32'h4000);
        rd(4'h4, 4'h0, 32'h4000);
        $display("test rollover done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
